// file: omsc_pkg.sv
// Package for the optical module sideband control block
package omsc_pkg;

  // Avalon-MM register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_LIVE = 8'h0c;

  // Control register fields
  localparam int CTRL_PWR_OVERRIDE = 0;
  localparam int CTRL_PWR_SET = 1;
  localparam int CTRL_PIN_DISABLE = 2;
  localparam int CTRL_PIN_LOSL = 3;
  localparam int CTRL_FAST_LOS = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Latched flag fields
  localparam int FLG_LOS = 0;
  localparam int FLG_UNLOCK = 1;
  localparam int FLG_TXFAULT = 2;
  localparam int FLG_RXPWR = 3;
  localparam int FLG_W = 4;

  // Timing: times in microseconds, clock 200 MHz
  localparam int CLK_MHZ = 200;
  localparam int T_RESET_MIN_US = 10;
  localparam int T_RECOVER_US = 20;
  localparam int T_SERIAL_US = 20;
  localparam int T_MODE_US = 1;
  localparam int T_RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
  localparam int T_RECOVER_CYC = T_RECOVER_US * CLK_MHZ;
  localparam int T_SERIAL_CYC = T_SERIAL_US * CLK_MHZ;
  localparam int T_MODE_CYC = T_MODE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    OMSC_RESET,
    OMSC_INIT,
    OMSC_RUN
  } omsc_state_t;

  // Analog-side event inputs, from pins
  typedef struct packed {
    logic receive_signal_loss_flag;
    logic rx_unlock;
    logic tx_fault;
    logic rx_pwr_alarm;
    logic tx_in_low;
  } omsc_evt_t;

  // Pins driven toward the analog front end and host
  typedef struct packed {
    logic low_power;
    logic tx_disable;
    logic rx_squelch;
    logic tx_squelch;
    logic fully_functional;
  } omsc_ctl_t;

endpackage

// file: omsc_top.sv
// Sideband control of a pluggable optical module
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module omsc_top
  import omsc_pkg::*;
#(
  parameter int RESET_MIN_CYC = T_RESET_MIN_CYC,
  parameter int RECOVER_CYC = T_RECOVER_CYC,
  parameter int SERIAL_CYC = T_SERIAL_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic module_reset_low_pin,
  input wire logic shared_power_or_disable_pin,
  input wire omsc_pkg::omsc_evt_t evt_in,
  output omsc_pkg::omsc_ctl_t ctl_out,
  output logic shared_interrupt_or_loss_pin
);
  import omsc_pkg::*;

  // Two-stage synchronisers for all pin inputs
  logic [6:0] s1_q, s2_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_q <= 7'h7f;
      s2_q <= 7'h7f;
    end else begin
      s1_q <= {module_reset_low_pin, shared_power_or_disable_pin, evt_in};
      s2_q <= s1_q;
    end
  end
  logic rst_pin_low, pd_pin;
  omsc_evt_t ev;
  assign rst_pin_low = ~s2_q[6];
  assign pd_pin = s2_q[5];
  assign ev = s2_q[4:0];

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // Reset sequencer
  omsc_state_t st_q, st_d;
  logic [15:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic bus_ok_q, bus_ok_d;
  logic [15:0] bcnt_q, bcnt_d;
  always_comb begin
    st_d = st_q;
    rcnt_d = rst_pin_low ? sat_inc(rcnt_q) : 16'h0000;
    tcnt_d = tcnt_q;
    bcnt_d = sat_inc(bcnt_q);
    bus_ok_d = bus_ok_q | (bcnt_q >= 16'(SERIAL_CYC - 1));
    unique case (st_q)
      OMSC_RESET: begin
        tcnt_d = 16'h0000;
        if (!rst_pin_low) st_d = OMSC_INIT;
      end
      OMSC_INIT: begin
        tcnt_d = sat_inc(tcnt_q);
        if (tcnt_q >= 16'(RECOVER_CYC - 1)) st_d = OMSC_RUN;
      end
      OMSC_RUN: ;
    endcase
    // A pulse of the minimum width always restarts the sequence
    if (rcnt_q >= 16'(RESET_MIN_CYC - 1)) st_d = OMSC_RESET;
  end

  // Registers and flags
  logic [4:0] ctrl_q, ctrl_d;
  logic [FLG_W-1:0] flg_q, flg_d;
  logic [31:0] rd_q, rd_d;
  logic wait_q, wait_d;
  logic in_run;
  assign in_run = (st_q == OMSC_RUN);
  logic acc;
  assign acc = (avs_read | avs_write) & bus_ok_q;
  logic [FLG_W-1:0] evt_now;
  assign evt_now = {ev.rx_pwr_alarm, ev.tx_fault, ev.rx_unlock, ev.receive_signal_loss_flag};

  always_comb begin
    ctrl_d = ctrl_q;
    rd_d = rd_q;
    // Answer one cycle after the request; held off until the bus is ready
    wait_d = 1'b1;
    if (acc && wait_q) wait_d = 1'b0;
    // Set wins over the read-clear so no event is lost
    flg_d = flg_q;
    if (acc && wait_q && avs_read && {avs_address, 2'b00} == REG_FLAGS)
      flg_d = 4'h0;
    if (in_run) flg_d = flg_d | evt_now;
    if (acc && wait_q) begin
      unique case ({avs_address, 2'b00})
        REG_CTRL: rd_d = {27'h0, ctrl_q};
        REG_STATUS: rd_d = {27'h0, ctl_out};
        REG_FLAGS: rd_d = {28'h0, flg_q};
        REG_LIVE: rd_d = {25'h0, st_q == OMSC_RUN, bus_ok_q, ev};
        default: rd_d = 32'h0;
      endcase
      if (avs_write && {avs_address, 2'b00} == REG_CTRL)
        ctrl_d = avs_writedata[4:0];
      if (avs_write) rd_d = 32'h0;
    end
    // Entering the reset sequence drops control and every latched flag
    if (st_q == OMSC_RESET) begin
      ctrl_d = CTRL_RESET;
      flg_d = '0;
    end
  end

  // Output pin logic
  omsc_ctl_t ctl_d;
  logic int_d;
  logic lp_req, tx_off_req, rx_dead, fast_los;
  always_comb begin
    // Shared pin takes one meaning or the other per control bit
    lp_req = ~ctrl_q[CTRL_PIN_DISABLE] & pd_pin;
    tx_off_req = ctrl_q[CTRL_PIN_DISABLE] & pd_pin;
    // Override takes low power from the set bit and ignores the pin
    if (ctrl_q[CTRL_PWR_OVERRIDE])
      lp_req = ctrl_q[CTRL_PWR_SET];
    ctl_d.low_power = lp_req | ~in_run;
    ctl_d.tx_disable = tx_off_req | ~in_run;
    ctl_d.rx_squelch = ev.receive_signal_loss_flag | ~in_run;
    ctl_d.tx_squelch = ev.tx_in_low | ~in_run;
    ctl_d.fully_functional = in_run & ~lp_req;
    rx_dead = ev.receive_signal_loss_flag;
    fast_los = ctrl_q[CTRL_FAST_LOS];
    // Loss meaning: live in fast mode, else the latched bit or the live loss
    if (ctrl_q[CTRL_PIN_LOSL])
      int_d = fast_los ? ~rx_dead : ~(flg_q[FLG_LOS] | rx_dead);
    else
      int_d = ~(|flg_q);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= OMSC_RESET;
      rcnt_q <= 16'h0000;
      tcnt_q <= 16'h0000;
      bcnt_q <= 16'h0000;
      bus_ok_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      flg_q <= 4'h0;
      rd_q <= 32'h0;
      wait_q <= 1'b1;
      ctl_out <= 5'b11110;
      shared_interrupt_or_loss_pin <= 1'b1;
    end else begin
      st_q <= st_d;
      rcnt_q <= rcnt_d;
      tcnt_q <= tcnt_d;
      bcnt_q <= bcnt_d;
      bus_ok_q <= bus_ok_d;
      ctrl_q <= ctrl_d;
      flg_q <= flg_d;
      rd_q <= rd_d;
      wait_q <= wait_d;
      ctl_out <= ctl_d;
      shared_interrupt_or_loss_pin <= int_d;
    end
  end
  assign avs_readdata = rd_q;
  assign avs_waitrequest = wait_q;

  a_lowpwr_follows: assert property (@(posedge mclk) disable iff (srst)
    (in_run && !ctrl_q[CTRL_PWR_OVERRIDE] && !ctrl_q[CTRL_PIN_DISABLE]
     && pd_pin) |=> ctl_out.low_power)
    else $error("low power not taken");
  a_override_set: assert property (@(posedge mclk) disable iff (srst)
    (ctrl_q[CTRL_PWR_OVERRIDE] && ctrl_q[CTRL_PWR_SET]) |=>
    ctl_out.low_power)
    else $error("override did not force low power");
  a_flag_latched: assert property (@(posedge mclk) disable iff (srst)
    (flg_q[FLG_LOS] && !(acc && wait_q && avs_read)
     && st_q != OMSC_RESET) |=> flg_q[FLG_LOS])
    else $error("flag dropped without read");
  a_los_sets: assert property (@(posedge mclk) disable iff (srst)
    (in_run && ev.receive_signal_loss_flag) |=> flg_q[FLG_LOS])
    else $error("loss flag not set");
  a_int_assert: assert property (@(posedge mclk) disable iff (srst)
    (|flg_q && !ctrl_q[CTRL_PIN_LOSL]) |=>
    !shared_interrupt_or_loss_pin)
    else $error("interrupt not asserted");
  a_squelch_rx: assert property (@(posedge mclk) disable iff (srst)
    ev.receive_signal_loss_flag |=> ctl_out.rx_squelch)
    else $error("rx not squelched");
  a_squelch_tx: assert property (@(posedge mclk) disable iff (srst)
    ev.tx_in_low |=> ctl_out.tx_squelch)
    else $error("tx not squelched");
  a_resume_rx: assert property (@(posedge mclk) disable iff (srst)
    (in_run && !ev.receive_signal_loss_flag) |=> !ctl_out.rx_squelch)
    else $error("rx not restored");
  a_fast_los: assert property (@(posedge mclk) disable iff (srst)
    (ctrl_q[CTRL_PIN_LOSL] && ctrl_q[CTRL_FAST_LOS]) |=>
    (shared_interrupt_or_loss_pin == !$past(ev.receive_signal_loss_flag)))
    else $error("fast loss pin wrong");

  // Bus handshake: stalled until ready, then one answer cycle
  a_bus_gated: assert property (@(posedge mclk) disable iff (srst)
    !bus_ok_q |=> avs_waitrequest)
    else $error("bus answered before ready");
  a_wait_answer: assert property (@(posedge mclk) disable iff (srst)
    (acc && wait_q) |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (@(posedge mclk) disable iff (srst)
    !wait_q |=> wait_q)
    else $error("answer held too long");

  // Reset sequencer: a full pulse always restarts, recovery is bounded
  a_reset_pulse: assert property (@(posedge mclk) disable iff (srst)
    (rcnt_q >= 16'(RESET_MIN_CYC - 1)) |=> (st_q == OMSC_RESET))
    else $error("minimum pulse did not reset");
  a_reset_exit: assert property (@(posedge mclk) disable iff (srst)
    (st_q == OMSC_RESET && !rst_pin_low
     && rcnt_q < 16'(RESET_MIN_CYC - 1)) |=> (st_q == OMSC_INIT))
    else $error("reset release not taken");
  a_recover_run: assert property (@(posedge mclk) disable iff (srst)
    (st_q == OMSC_INIT && tcnt_q >= 16'(RECOVER_CYC - 1)
     && rcnt_q < 16'(RESET_MIN_CYC - 1)) |=> in_run)
    else $error("recovery took too long");
  a_not_ready: assert property (@(posedge mclk) disable iff (srst)
    !in_run |=> !ctl_out.fully_functional)
    else $error("functional before recovery");
  a_run_full: assert property (@(posedge mclk) disable iff (srst)
    (in_run && !lp_req) |=> ctl_out.fully_functional)
    else $error("not functional in run");

  // Power and shared pin meanings
  a_full_power: assert property (@(posedge mclk) disable iff (srst)
    (in_run && !ctrl_q[CTRL_PWR_OVERRIDE] && !ctrl_q[CTRL_PIN_DISABLE]
     && !pd_pin) |=> !ctl_out.low_power)
    else $error("low power not left");
  a_override_clr: assert property (@(posedge mclk) disable iff (srst)
    (in_run && ctrl_q[CTRL_PWR_OVERRIDE] && !ctrl_q[CTRL_PWR_SET]) |=>
    !ctl_out.low_power)
    else $error("override did not restore power");
  a_disable_pin: assert property (@(posedge mclk) disable iff (srst)
    (ctrl_q[CTRL_PIN_DISABLE] && pd_pin) |=> ctl_out.tx_disable)
    else $error("disable meaning not taken");
  a_disable_no_lp: assert property (@(posedge mclk) disable iff (srst)
    (in_run && ctrl_q[CTRL_PIN_DISABLE] && !ctrl_q[CTRL_PWR_OVERRIDE]) |=>
    !ctl_out.low_power)
    else $error("disable meaning lowered power");

  // Flags and the shared interrupt or loss pin
  a_read_clears: assert property (@(posedge mclk) disable iff (srst)
    (acc && wait_q && avs_read && {avs_address, 2'b00} == REG_FLAGS) |=>
    ((flg_q & ~$past(evt_now)) == '0))
    else $error("flag read did not clear");
  a_int_release: assert property (@(posedge mclk) disable iff (srst)
    (!(|flg_q) && !ctrl_q[CTRL_PIN_LOSL]) |=> shared_interrupt_or_loss_pin)
    else $error("interrupt not released");
  a_loss_latched: assert property (@(posedge mclk) disable iff (srst)
    (ctrl_q[CTRL_PIN_LOSL] && !ctrl_q[CTRL_FAST_LOS]
     && (flg_q[FLG_LOS] || ev.receive_signal_loss_flag)) |=> !shared_interrupt_or_loss_pin)
    else $error("loss meaning not shown");
endmodule // omsc_top

// file: omsc_host_model.sv
// Host-side pin model that drives the module reset pin
`timescale 1ns/1ps
module omsc_host_model #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic pulse_req,
  output logic module_reset_low_pin
);
  int cnt = 0;
  // Pulse never shorter than WIDTH, so the reset is taken if WIDTH is at least RESET_MIN_CYC
  always @(posedge mclk) begin
    if (pulse_req && cnt == 0) cnt <= WIDTH;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign module_reset_low_pin = (cnt == 0);
endmodule // omsc_host_model

// file: testbench.sv
// Self-checking bench for the optical module sideband control block
`timescale 1ns/1ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
  mismatches++; $display("unexpected at %0t: %s", $time, m); end end
module testbench;
  import omsc_pkg::*;
  localparam int RMIN = 8;
  localparam int RREC = 16;
  logic mclk = 0;
  logic srst = 1;
  logic [3:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic module_reset_low_pin;
  logic shared_power_or_disable_pin = 0;
  logic shared_interrupt_or_loss_pin;
  logic pulse_req = 0;
  omsc_evt_t evt_in = '0;
  omsc_ctl_t ctl_out;
  logic [31:0] expq[$];
  int mismatches = 0;
  int check_count = 0;
  omsc_top #(.RESET_MIN_CYC(RMIN), .RECOVER_CYC(RREC), .SERIAL_CYC(16))
    omsc_top_inst (.mclk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .module_reset_low_pin,
    .shared_power_or_disable_pin, .evt_in, .ctl_out,
    .shared_interrupt_or_loss_pin);
  omsc_host_model #(.WIDTH(RMIN)) omsc_host_model_inst (.mclk, .pulse_req,
    .module_reset_low_pin);
  initial forever #2.5 mclk = ~mclk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a[5:2];
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(0, a, '0);
  endtask
  // Upper bits are don't-care, so they carry random noise
  task automatic wt(input logic [4:0] v);
    bus(1, REG_CTRL, {27'($urandom()), v});
  endtask
  // Read results are compared as they appear on the bus
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      `CHK(avs_readdata, expq.pop_front(), "read data")
  end
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(32'h10190a3d));
    repeat (10) @(posedge mclk);
    srst <= 0;
    rd(REG_CTRL, '0);
    for (int i = 0; i < 300 && ctl_out.fully_functional !== 1'b1; i++) gap(1);
    `CHK(ctl_out.fully_functional, 1'b1, "bring-up")
    rd(REG_LIVE, 32'h60);
    rd(REG_STATUS, 32'h1);
    rd(8'h20, '0);
    for (int i = 0; i < FLG_W; i++) begin
      evt_in <= omsc_evt_t'(5'h10 >> i);
      gap(8);
      `CHK(shared_interrupt_or_loss_pin, 1'b0, "int set")
      `CHK(ctl_out.rx_squelch, i == 0, "rx squelch")
      evt_in <= '0;
      gap(8);
      `CHK(shared_interrupt_or_loss_pin, 1'b0, "int held")
      `CHK(ctl_out.rx_squelch, 1'b0, "rx resume")
      rd(REG_FLAGS, 32'h1 << i);
      gap(8);
      `CHK(shared_interrupt_or_loss_pin, 1'b1, "int free")
    end
    evt_in <= 5'h01;
    gap(8);
    `CHK(ctl_out.tx_squelch, 1'b1, "tx squelch")
    evt_in <= '0;
    wt(5'h03);
    gap(8);
    `CHK(ctl_out.low_power, 1'b1, "override")
    rd(REG_CTRL, 32'h3);
    wt(5'h00);
    gap(8);
    `CHK(ctl_out.low_power, 1'b0, "restore")
    shared_power_or_disable_pin <= 1;
    gap(8);
    `CHK(ctl_out.low_power, 1'b1, "pin power")
    wt(5'h01);
    gap(8);
    `CHK(ctl_out.low_power, 1'b0, "override off")
    wt(5'h00);
    shared_power_or_disable_pin <= 0;
    gap(8);
    `CHK(ctl_out.low_power, 1'b0, "pin full")
    shared_power_or_disable_pin <= 1;
    wt(5'h04);
    gap(T_MODE_CYC);
    `CHK(ctl_out.tx_disable, 1'b1, "pin disable")
    `CHK(ctl_out.low_power, 1'b0, "pin no lp")
    shared_power_or_disable_pin <= 0;
    gap(8);
    `CHK(ctl_out.tx_disable, 1'b0, "disable off")
    wt(5'h18);
    evt_in.receive_signal_loss_flag <= 1;
    gap(8);
    `CHK(shared_interrupt_or_loss_pin, 1'b0, "fast loss")
    evt_in.receive_signal_loss_flag <= 0;
    gap(8);
    `CHK(shared_interrupt_or_loss_pin, 1'b1, "fast free")
    wt(5'h00);
    gap(T_MODE_CYC);
    `CHK(shared_interrupt_or_loss_pin, 1'b0, "mode back")
    rd(REG_FLAGS, 32'h1);
    wt(5'h08);
    evt_in.receive_signal_loss_flag <= 1;
    gap(8);
    `CHK(shared_interrupt_or_loss_pin, 1'b0, "slow loss")
    evt_in.receive_signal_loss_flag <= 0;
    gap(8);
    `CHK(shared_interrupt_or_loss_pin, 1'b0, "loss latched")
    rd(REG_FLAGS, 32'h1);
    gap(8);
    `CHK(shared_interrupt_or_loss_pin, 1'b1, "loss free")
    wt(5'h00);
    gap(8);
    pulse_req <= 1;
    gap(1);
    pulse_req <= 0;
    gap(RMIN + 6);
    `CHK(ctl_out.fully_functional, 1'b0, "pin reset")
    gap(RREC + 12);
    `CHK(ctl_out.fully_functional, 1'b1, "recovered")
    final_report();
  end
endmodule // testbench
